// *** verilog/port_host.sv ***
`timescale 1ns/1ps

module port_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  sram_link.host           link
);
  import dpram_pkg::*;

  logic [7:0]     ctrl_reg;
  addr_type       addr_reg;
  word_type       wdata_reg;
  word_type       rdata_reg;
  logic           done_reg;
  host_state_type state_reg;
  logic [2:0]     wait_reg;
  logic [31:0]    prdata_reg;
  logic           pready_reg;
  logic           pslverr_reg;
  logic           ads_n_reg;
  logic           cs_n_reg;
  logic           cs_reg;
  logic           adv_n_reg;
  logic           clr_n_reg;
  lane_type       lane_n_reg;
  logic           oe_n_reg;
  logic           wnr_reg;
  word_type       dq_reg;
  lane_type       dq_oe_reg;

  logic apb_wr;
  logic go;
  logic mapped;
  logic [1:0] op_req;

  assign op_req = pwdata[`CTRL_OP_LSB +: 2];
  assign mapped = (paddr == `REG_CTRL) | (paddr == `REG_ADDR) | (paddr == `REG_WDATA) |
                  (paddr == `REG_RDATA) | (paddr == `REG_STATUS);
  assign apb_wr = psel & penable & pready_reg & pwrite & mapped;
  assign go     = apb_wr & (paddr == `REG_CTRL) & pwdata[`CTRL_GO] & (state_reg == HOST_IDLE);

  // Answer in the first access cycle: ready is raised by the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= psel & ~penable;
      pslverr_reg <= psel & ~penable & ~mapped;
      if (psel & ~penable) begin
        unique case (paddr)
          `REG_CTRL:   prdata_reg <= {24'h00_0000, ctrl_reg};
          `REG_ADDR:   prdata_reg <= 32'(addr_reg);
          `REG_WDATA:  prdata_reg <= 32'(wdata_reg);
          `REG_RDATA:  prdata_reg <= 32'(rdata_reg);
          `REG_STATUS: prdata_reg <= {30'h0000_0000, done_reg, state_reg != HOST_IDLE};
          default:     prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // The go bit never reads back; control, address and write-data writes while busy are ignored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg  <= 8'h00;
      addr_reg  <= '0;
      wdata_reg <= '0;
    end else if (apb_wr && state_reg == HOST_IDLE) begin
      if (paddr == `REG_CTRL)  ctrl_reg  <= {pwdata[7:1], 1'b0};
      if (paddr == `REG_ADDR)  addr_reg  <= pwdata[`ADDR_BITS-1:0];
      if (paddr == `REG_WDATA) wdata_reg <= pwdata[`DATA_BITS-1:0];
    end
  end

  // Completion sets done; a set in the clearing cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
    end else if (state_reg == HOST_WAIT && wait_reg == 3'h1) begin
      done_reg <= 1'b1;
    end else if (apb_wr && paddr == `REG_STATUS && pwdata[`STAT_DONE]) begin
      done_reg <= 1'b0;
    end
  end

  // One access: strobes and selects driven for one cycle, output enable and lane selects held until the read latency is waited.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= HOST_IDLE;
      wait_reg   <= 3'h0;
      rdata_reg  <= '0;
      ads_n_reg  <= 1'b1;
      cs_n_reg   <= 1'b1;
      cs_reg     <= 1'b0;
      adv_n_reg  <= 1'b1;
      clr_n_reg  <= 1'b1;
      lane_n_reg <= 2'h3;
      oe_n_reg   <= 1'b1;
      wnr_reg    <= 1'b1;
      dq_reg     <= '0;
      dq_oe_reg  <= 2'h0;
    end else begin
      unique case (state_reg)
        HOST_IDLE: begin
          if (go) begin
            state_reg  <= HOST_ISSUE;
            cs_n_reg   <= 1'b0;
            cs_reg     <= 1'b1;
            // Advance is held low on every access and strobe joins a clear, so
            // the device's load and clear priority over counting is used on every load and clear.
            ads_n_reg  <= ~(op_req == `OP_LOAD || op_req == `OP_CLEAR);
            adv_n_reg  <= 1'b0;
            clr_n_reg  <= ~(op_req == `OP_CLEAR);
            lane_n_reg <= ~pwdata[`CTRL_LANE_LSB +: 2];
            wnr_reg    <= ~pwdata[`CTRL_WRITE];
            oe_n_reg   <= pwdata[`CTRL_WRITE];
            dq_reg     <= wdata_reg;
            dq_oe_reg  <= {2{pwdata[`CTRL_WRITE]}} & pwdata[`CTRL_LANE_LSB +: 2];
          end
        end
        HOST_ISSUE: begin
          state_reg <= HOST_WAIT;
          wait_reg  <= ctrl_reg[`CTRL_PIPE] ? `PIPE_LAT + 3'h1 : `FLOW_LAT + 3'h1;
          cs_n_reg  <= 1'b1;
          cs_reg    <= 1'b0;
          ads_n_reg <= 1'b1;
          adv_n_reg <= 1'b1;
          clr_n_reg <= 1'b1;
          wnr_reg   <= 1'b1;
          dq_oe_reg <= 2'h0;
        end
        HOST_WAIT: begin
          wait_reg <= wait_reg - 3'h1;
          if (wait_reg == 3'h1) begin
            state_reg  <= HOST_IDLE;
            rdata_reg  <= link.dq;
            oe_n_reg   <= 1'b1;
            lane_n_reg <= 2'h3;
          end
        end
      endcase
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  assign link.address_strobe_n      = ads_n_reg;
  assign link.chip_sel_low_active_n = cs_n_reg;
  assign link.chip_sel_high_active  = cs_reg;
  assign link.burst_advance_n       = adv_n_reg;
  assign link.burst_clear_n         = clr_n_reg;
  assign link.low_lane_sel_n        = lane_n_reg[0];
  assign link.high_lane_sel_n       = lane_n_reg[1];
  assign link.out_drive_en_n        = oe_n_reg;
  assign link.write_not_read        = wnr_reg;
  assign link.latency_mode_sel      = ctrl_reg[`CTRL_PIPE];
  assign link.address               = addr_reg;
  assign link.host_dq_out           = dq_reg;
  assign link.host_dq_oe            = dq_oe_reg;

endmodule

// *** verilog/dpram_cfg.svh ***
`ifndef DPRAM_CFG_SVH
`define DPRAM_CFG_SVH

// Array shape: 14, 15 or 16 address bits and a word of 16 or 18 bits.
`define ADDR_BITS 14
`define DEPTH     16384
`define DATA_BITS 18
`define LOW_BITS  9

// Host register map, byte addresses on the APB side.
`define REG_CTRL   8'h00
`define REG_ADDR   8'h04
`define REG_WDATA  8'h08
`define REG_RDATA  8'h0c
`define REG_STATUS 8'h10

// Field positions.
`define CTRL_GO       0
`define CTRL_OP_LSB   1
`define CTRL_WRITE    3
`define CTRL_PIPE     4
`define CTRL_LANE_LSB 5
`define STAT_BUSY     0
`define STAT_DONE     1

// Access kinds.
`define OP_LOAD    2'h0
`define OP_ADVANCE 2'h1
`define OP_CLEAR   2'h2

// Cycles from the device's sampling edge to visible read data.
`define FLOW_LAT 3'h1
`define PIPE_LAT 3'h2

`endif

// *** verilog/dpram_pkg.sv ***
`include "dpram_cfg.svh"

package dpram_pkg;

  typedef logic [`ADDR_BITS-1:0] addr_type;
  typedef logic [`DATA_BITS-1:0] word_type;
  typedef logic [1:0]            lane_type;

  typedef enum logic [1:0] {HOST_IDLE, HOST_ISSUE, HOST_WAIT} host_state_type;

  // Bit 0 of the lane vector covers the low lane, bit 1 the high lane.
  function automatic word_type lane_mask(input lane_type lanes);
    return {{(`DATA_BITS-`LOW_BITS){lanes[1]}}, {`LOW_BITS{lanes[0]}}};
  endfunction

endpackage

// *** verilog/sram_link.sv ***
`timescale 1ns/1ps

interface sram_link;
  import dpram_pkg::*;

  logic     address_strobe_n;
  logic     chip_sel_low_active_n;
  logic     chip_sel_high_active;
  logic     burst_advance_n;
  logic     burst_clear_n;
  logic     low_lane_sel_n;
  logic     high_lane_sel_n;
  logic     out_drive_en_n;
  logic     write_not_read;
  logic     latency_mode_sel;
  addr_type address;
  word_type host_dq_out;
  lane_type host_dq_oe;
  word_type dev_dq_out;
  lane_type dev_dq_oe;
  word_type dq;

  // An undriven lane reads as zero; both ends driving a lane would collide.
  assign dq = (dev_dq_out & lane_mask(dev_dq_oe)) | (host_dq_out & lane_mask(host_dq_oe));

  modport dev (
    input  address_strobe_n,
    input  chip_sel_low_active_n,
    input  chip_sel_high_active,
    input  burst_advance_n,
    input  burst_clear_n,
    input  low_lane_sel_n,
    input  high_lane_sel_n,
    input  out_drive_en_n,
    input  write_not_read,
    input  latency_mode_sel,
    input  address,
    input  dq,
    output dev_dq_out,
    output dev_dq_oe
  );

  modport host (
    output address_strobe_n,
    output chip_sel_low_active_n,
    output chip_sel_high_active,
    output burst_advance_n,
    output burst_clear_n,
    output low_lane_sel_n,
    output high_lane_sel_n,
    output out_drive_en_n,
    output write_not_read,
    output latency_mode_sel,
    output address,
    output host_dq_out,
    output host_dq_oe,
    input  dq
  );

endinterface

// *** verilog/read_out_stage.sv ***
`timescale 1ns/1ps

module read_out_stage (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               pipe_mode,
  input  wire dpram_pkg::word_type rdata,
  input  wire dpram_pkg::lane_type rd_oe,
  output dpram_pkg::word_type     dq_out,
  output dpram_pkg::lane_type     dq_oe
);
  import dpram_pkg::*;

  word_type stage_reg;
  lane_type stage_oe_reg;
  word_type out_reg;
  lane_type out_oe_reg;

  // The extra stage only steers the output in pipelined mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_reg    <= '0;
      stage_oe_reg <= 2'h0;
    end else begin
      stage_reg    <= rdata;
      stage_oe_reg <= rd_oe;
    end
  end

  // Flow-through loads the pins straight from the array and skips a stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg    <= '0;
      out_oe_reg <= 2'h0;
    end else if (pipe_mode) begin
      out_reg    <= stage_reg;
      out_oe_reg <= stage_oe_reg;
    end else begin
      out_reg    <= rdata;
      out_oe_reg <= rd_oe;
    end
  end

  assign dq_out = out_reg;
  assign dq_oe  = out_oe_reg;

endmodule

// *** verilog/dual_port_device.sv ***
// How it works
// - Two independent ports share one array.
// - Depth 16K/32K/64K, word 16 or 18 bits.
// - Strobe low loads address into burst counter.
// - Selected only when both chip selects active.
// - Advance low increments counter every clock.
// - Strobe or clear low overrides advance.
// - Clear low forces counter to zero always.
// - Low lane select gates lower lane bits.
// - High lane select gates upper lane bits.
// - Read drives lane only with select and enable.
// - Host writes with write_not_read low.
// - Mode low flow-through, high pipelined.
// - Each port runs from its own clock; here both ports run on pclk.
// - Burst counter works in both modes.
// - Pipelined adds output register, flow bypasses it.
// - Deselect powers down; pipelined needs reselect cycle; here deselect only blocks writes and read drive, with no reselect cycle.
// - Counter spans array and wraps to zero.
// - Same-word double write has no set winner; here the right port wins.
`timescale 1ns/1ps

module dual_port_device (
  input wire logic pclk,
  input wire logic presetn,
  sram_link.dev    left_port,
  sram_link.dev    right_port
);
  import dpram_pkg::*;

  localparam int PORTS = 2;

  // The shared array is not reset; its contents are undefined at power-up.
  word_type mem [`DEPTH];

  // Per-port copies of the pins so both ports share one generate body.
  logic     ads_n_pin   [PORTS];
  logic     sel_pin     [PORTS];
  logic     adv_n_pin   [PORTS];
  logic     clr_n_pin   [PORTS];
  lane_type lanes_pin   [PORTS];
  logic     oe_n_pin    [PORTS];
  logic     wnr_pin     [PORTS];
  logic     mode_pin    [PORTS];
  addr_type addr_pin    [PORTS];
  word_type dq_pin      [PORTS];

  // Signals produced per port.
  addr_type acc_addr    [PORTS];
  logic     wr_en       [PORTS];
  word_type wr_mask     [PORTS];
  word_type wr_data     [PORTS];
  word_type rd_data     [PORTS];
  lane_type rd_oe       [PORTS];
  logic     mode_now    [PORTS];
  word_type dq_drv      [PORTS];
  lane_type dq_drv_oe   [PORTS];

  assign ads_n_pin[0] = left_port.address_strobe_n;
  assign sel_pin[0]   = ~left_port.chip_sel_low_active_n & left_port.chip_sel_high_active;
  assign adv_n_pin[0] = left_port.burst_advance_n;
  assign clr_n_pin[0] = left_port.burst_clear_n;
  assign lanes_pin[0] = {~left_port.high_lane_sel_n, ~left_port.low_lane_sel_n};
  assign oe_n_pin[0]  = left_port.out_drive_en_n;
  assign wnr_pin[0]   = left_port.write_not_read;
  assign mode_pin[0]  = left_port.latency_mode_sel;
  assign addr_pin[0]  = left_port.address;
  assign dq_pin[0]    = left_port.dq;

  assign ads_n_pin[1] = right_port.address_strobe_n;
  assign sel_pin[1]   = ~right_port.chip_sel_low_active_n & right_port.chip_sel_high_active;
  assign adv_n_pin[1] = right_port.burst_advance_n;
  assign clr_n_pin[1] = right_port.burst_clear_n;
  assign lanes_pin[1] = {~right_port.high_lane_sel_n, ~right_port.low_lane_sel_n};
  assign oe_n_pin[1]  = right_port.out_drive_en_n;
  assign wnr_pin[1]   = right_port.write_not_read;
  assign mode_pin[1]  = right_port.latency_mode_sel;
  assign addr_pin[1]  = right_port.address;
  assign dq_pin[1]    = right_port.dq;

  assign left_port.dev_dq_out  = dq_drv[0];
  assign left_port.dev_dq_oe   = dq_drv_oe[0];
  assign right_port.dev_dq_out = dq_drv[1];
  assign right_port.dev_dq_oe  = dq_drv_oe[1];

  // Both ports run on pclk here; each keeps its own registers so the two
  // never interact except through the array itself.
  genvar p;
  generate
    for (p = 0; p < PORTS; p++) begin : g_port
      logic     ads_reg;
      logic     sel_reg;
      logic     adv_reg;
      logic     clr_reg;
      lane_type lanes_reg;
      logic     oe_reg;
      logic     wnr_reg;
      logic     mode_reg;
      addr_type addr_reg;
      word_type din_reg;
      addr_type cnt_reg;
      addr_type cnt_next;

      // Every control, address and data pin is captured before use; the
      // host is on the same clock, so no synchroniser is needed.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ads_reg   <= 1'b0;
          sel_reg   <= 1'b0;
          adv_reg   <= 1'b0;
          clr_reg   <= 1'b0;
          lanes_reg <= 2'h0;
          oe_reg    <= 1'b0;
          wnr_reg   <= 1'b1;
          mode_reg  <= 1'b0;
          addr_reg  <= '0;
          din_reg   <= '0;
        end else begin
          ads_reg   <= ~ads_n_pin[p];
          sel_reg   <= sel_pin[p];
          adv_reg   <= ~adv_n_pin[p];
          clr_reg   <= ~clr_n_pin[p];
          lanes_reg <= lanes_pin[p];
          oe_reg    <= ~oe_n_pin[p];
          wnr_reg   <= wnr_pin[p];
          mode_reg  <= mode_pin[p];
          addr_reg  <= addr_pin[p];
          din_reg   <= dq_pin[p];
        end
      end

      // Clear beats load, load beats advance; the counter ignores the mode.
      always_comb begin
        if (clr_reg) begin
          cnt_next = '0;
        end else if (ads_reg) begin
          cnt_next = addr_reg;
        end else if (adv_reg) begin
          cnt_next = addr_type'(cnt_reg + 1'b1);
        end else begin
          cnt_next = cnt_reg;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_reg <= '0;
        end else begin
          cnt_reg <= cnt_next;
        end
      end

      assign acc_addr[p] = cnt_next;
      assign wr_en[p]    = sel_reg & ~wnr_reg & (|lanes_reg);
      assign wr_mask[p]  = lane_mask(lanes_reg);
      assign wr_data[p]  = din_reg;
      assign rd_data[p]  = mem[acc_addr[p]];
      // A deselected cycle carries no drive, so outputs fall idle.
      assign rd_oe[p]    = {2{sel_reg & wnr_reg & oe_reg}} & lanes_reg;
      assign mode_now[p] = mode_reg;

      read_out_stage u_out (
        .pclk      (pclk),
        .presetn   (presetn),
        .pipe_mode (mode_now[p]),
        .rdata     (rd_data[p]),
        .rd_oe     (rd_oe[p]),
        .dq_out    (dq_drv[p]),
        .dq_oe     (dq_drv_oe[p])
      );
    end
  endgenerate

  // Only the selected lanes change. On a same-word collision the right port
  // is applied last and wins, which is one of the permitted outcomes.
  always_ff @(posedge pclk) begin
    for (int i = 0; i < PORTS; i++) begin
      if (wr_en[i]) begin
        mem[acc_addr[i]] <= (mem[acc_addr[i]] & ~wr_mask[i]) | (wr_data[i] & wr_mask[i]);
      end
    end
  end

endmodule

// *** verif/sram_link_properties.sv ***
`timescale 1ns/1ps

module sram_link_properties (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               chip_sel_low_active_n,
  input wire logic               chip_sel_high_active,
  input wire logic               low_lane_sel_n,
  input wire logic               high_lane_sel_n,
  input wire logic               out_drive_en_n,
  input wire logic               write_not_read,
  input wire logic               latency_mode_sel,
  input wire dpram_pkg::lane_type host_dq_oe,
  input wire dpram_pkg::lane_type dev_dq_oe
);
  import dpram_pkg::*;

  logic     acc;
  logic     rd_acc;
  lane_type exp_oe;

  assign acc    = !chip_sel_low_active_n && chip_sel_high_active;
  assign rd_acc = acc && write_not_read;
  // A lane may only be driven when its select and the output enable were both low.
  assign exp_oe = ~{high_lane_sel_n, low_lane_sel_n} & {2{~out_drive_en_n}};

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  flow_read_a: assert property (
    rd_acc && !latency_mode_sel |=> dev_dq_oe == 2'h0 ##1 dev_dq_oe == $past(exp_oe, 2)
    ##1 dev_dq_oe == 2'h0) else $error("flow-through read drive timing wrong");
  pipe_read_a: assert property (
    rd_acc && latency_mode_sel |=> dev_dq_oe == 2'h0 [*2] ##1 dev_dq_oe == $past(exp_oe, 3))
    else $error("pipelined read drive timing wrong");
  drive_cause_a: assert property (
    dev_dq_oe != 2'h0 |-> ($past(rd_acc, 2) && !$past(latency_mode_sel, 2))
    || ($past(rd_acc, 3) && $past(latency_mode_sel, 3)))
    else $error("device drove data without a selected read");
  write_quiet_a: assert property (
    acc && !write_not_read |=> dev_dq_oe == 2'h0 [*3]) else $error("device drove during write");
  host_lanes_a: assert property (
    acc && !write_not_read |-> host_dq_oe == ~{high_lane_sel_n, low_lane_sel_n})
    else $error("host write lanes differ from lane selects");
  no_clash_a: assert property (
    (dev_dq_oe & host_dq_oe) == 2'h0) else $error("both ends drive one lane");
  flow_gap_a: assert property (
    acc && !latency_mode_sel |=> !acc [*2]) else $error("flow-through access spacing short");
  pipe_gap_a: assert property (
    acc && latency_mode_sel |=> !acc [*3]) else $error("pipelined access spacing short");
endmodule

// *** verif/sync_dual_port_ram_ports_tb_top.sv ***
`timescale 1ns/1ps
`include "dpram_cfg.svh"

module sync_dual_port_ram_ports_tb_top;
  import dpram_pkg::*;

  logic        pclk;
  logic        presetn;
  logic [1:0]  psel, penable, pwrite;
  wire  [1:0]  pready, pslverr;
  logic [7:0]  paddr [2];
  logic [31:0] pwdata [2];
  wire  [31:0] prdata [2];
  int          errors;
  int          num_checks;

  sram_link link [2] ();

  for (genvar i = 0; i < 2; i++) begin : host_g
    port_host port_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel[i]),
      .penable(penable[i]), .pwrite(pwrite[i]), .paddr(paddr[i]), .pwdata(pwdata[i]),
      .prdata(prdata[i]), .pready(pready[i]), .pslverr(pslverr[i]), .link(link[i]));
  end

  dual_port_device dual_port_device_inst (.pclk(pclk), .presetn(presetn),
    .left_port(link[0]), .right_port(link[1]));

  sram_link_properties sram_link_properties_inst (.pclk(pclk), .presetn(presetn),
    .chip_sel_low_active_n(link[0].chip_sel_low_active_n),
    .chip_sel_high_active(link[0].chip_sel_high_active),
    .low_lane_sel_n(link[0].low_lane_sel_n), .high_lane_sel_n(link[0].high_lane_sel_n),
    .out_drive_en_n(link[0].out_drive_en_n), .write_not_read(link[0].write_not_read),
    .latency_mode_sel(link[0].latency_mode_sel), .host_dq_oe(link[0].host_dq_oe),
    .dev_dq_oe(link[0].dev_dq_oe));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic summarize();
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // The request stands until pready is seen high at a rising edge; data is taken there.
  task automatic apb(input int h, input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel[h]    <= 1'b1;
    penable[h] <= 1'b0;
    pwrite[h]  <= w;
    paddr[h]   <= a;
    pwdata[h]  <= d;
    @(posedge pclk);
    penable[h] <= 1'b1;
    @(posedge pclk);
    while (pready[h] !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    cmp_reg("pready", 32'h1, {31'h0, pready[h]});
    rd = prdata[h];
    err = pslverr[h];
    psel[h]    <= 1'b0;
    penable[h] <= 1'b0;
  endtask

  function automatic logic [31:0] ctrl(input logic g, input logic [1:0] op, input logic w,
                                       input logic p, input lane_type l);
    return {25'h0, l, p, w, op, g};
  endfunction

  task automatic access(input int h, input logic [1:0] op, input logic w, input logic p,
                        input lane_type l, input addr_type a, input word_type d,
                        output word_type q);
    logic [31:0] r;
    logic        e;
    int          n;
    apb(h, 1'b1, `REG_ADDR, {18'h0, a}, r, e);
    apb(h, 1'b1, `REG_WDATA, {14'h0, d}, r, e);
    apb(h, 1'b1, `REG_CTRL, ctrl(1'b0, op, w, p, l), r, e);
    apb(h, 1'b1, `REG_CTRL, ctrl(1'b1, op, w, p, l), r, e);
    n = 0;
    r = 32'h0;
    while (r[`STAT_DONE] !== 1'b1 && n < 20) begin
      apb(h, 1'b0, `REG_STATUS, 32'h0, r, e);
      n++;
    end
    cmp_reg("done flag", 32'h1, {31'h0, r[`STAT_DONE]});
    apb(h, 1'b1, `REG_STATUS, 32'h2, r, e);
    apb(h, 1'b0, `REG_RDATA, 32'h0, r, e);
    q = r[`DATA_BITS-1:0];
  endtask

  task automatic wr(input int h, input logic [1:0] op, input logic p, input lane_type l,
                    input addr_type a, input word_type d);
    word_type q;
    access(h, op, 1'b1, p, l, a, d, q);
  endtask

  task automatic chk_read(input int h, input logic [1:0] op, input logic p, input lane_type l,
                          input addr_type a, input word_type e);
    word_type q;
    access(h, op, 1'b0, p, l, a, 18'h0, q);
    cmp_reg("read word", {14'h0, e}, {14'h0, q});
  endtask

  task automatic test_regs();
    logic [31:0] r;
    logic        e;
    apb(0, 1'b1, `REG_ADDR, 32'h3fff, r, e);
    apb(0, 1'b0, `REG_ADDR, 32'h0, r, e);
    cmp_reg("address register", 32'h3fff, r);
    cmp_reg("mapped error", 32'h0, {31'h0, e});
    apb(0, 1'b0, 8'h14, 32'h0, r, e);
    cmp_reg("unmapped read error", 32'h1, {31'h0, e});
    apb(1, 1'b1, 8'h20, 32'h5, r, e);
    cmp_reg("unmapped write error", 32'h1, {31'h0, e});
  endtask

  // Each port writes a word the other one reads, once per output mode.
  task automatic test_cross();
    for (int p = 0; p < 2; p++) begin
      wr(0, `OP_LOAD, p[0], 2'h3, 14'h0123, 18'h2a5a5 ^ p[17:0]);
      chk_read(1, `OP_LOAD, ~p[0], 2'h3, 14'h0123, 18'h2a5a5 ^ p[17:0]);
      wr(1, `OP_LOAD, p[0], 2'h3, 14'h0124, 18'h1c3c3 ^ p[17:0]);
      chk_read(0, `OP_LOAD, p[0], 2'h3, 14'h0124, 18'h1c3c3 ^ p[17:0]);
    end
  endtask

  task automatic test_lanes();
    wr(0, `OP_LOAD, 1'b0, 2'h3, 14'h0200, 18'h3ffff);
    wr(0, `OP_LOAD, 1'b0, 2'h1, 14'h0200, 18'h15555);
    chk_read(1, `OP_LOAD, 1'b0, 2'h3, 14'h0200, 18'h3ff55);
    chk_read(1, `OP_LOAD, 1'b1, 2'h2, 14'h0200, 18'h3fe00);
    chk_read(0, `OP_LOAD, 1'b0, 2'h1, 14'h0200, 18'h00155);
    wr(1, `OP_LOAD, 1'b1, 2'h2, 14'h0200, 18'h00000);
    chk_read(0, `OP_LOAD, 1'b1, 2'h3, 14'h0200, 18'h00155);
  endtask

  // The counter is walked across the top of the array so that it wraps.
  task automatic test_burst();
    for (int p = 0; p < 2; p++) begin
      wr(0, `OP_LOAD, p[0], 2'h3, 14'h3ffe, 18'h0aaa0 + p[17:0]);
      wr(0, `OP_ADVANCE, p[0], 2'h3, 14'h0010, 18'h0bbb0 + p[17:0]);
      wr(0, `OP_ADVANCE, p[0], 2'h3, 14'h0010, 18'h0ccc0 + p[17:0]);
      chk_read(1, `OP_LOAD, p[0], 2'h3, 14'h3ffe, 18'h0aaa0 + p[17:0]);
      chk_read(1, `OP_ADVANCE, p[0], 2'h3, 14'h0010, 18'h0bbb0 + p[17:0]);
      chk_read(1, `OP_ADVANCE, p[0], 2'h3, 14'h0010, 18'h0ccc0 + p[17:0]);
      wr(1, `OP_LOAD, p[0], 2'h3, 14'h0777, 18'h01234);
      wr(1, `OP_CLEAR, p[0], 2'h3, 14'h0777, 18'h0ddd0 + p[17:0]);
      chk_read(0, `OP_LOAD, p[0], 2'h3, 14'h0000, 18'h0ddd0 + p[17:0]);
      chk_read(0, `OP_LOAD, p[0], 2'h3, 14'h0777, 18'h01234);
    end
  endtask

  // Both hosts run the same sequence, so their accesses reach the array in one cycle.
  task automatic test_collide();
    fork
      wr(0, `OP_LOAD, 1'b0, 2'h3, 14'h0051, 18'h11111);
      wr(1, `OP_LOAD, 1'b0, 2'h3, 14'h0052, 18'h22222);
    join
    fork
      chk_read(0, `OP_LOAD, 1'b0, 2'h3, 14'h0052, 18'h22222);
      chk_read(1, `OP_LOAD, 1'b1, 2'h3, 14'h0051, 18'h11111);
    join
    fork
      wr(0, `OP_LOAD, 1'b0, 2'h3, 14'h0050, 18'h30303);
      wr(1, `OP_LOAD, 1'b0, 2'h3, 14'h0050, 18'h04040);
    join
    chk_read(0, `OP_LOAD, 1'b0, 2'h3, 14'h0050, 18'h04040);
  endtask

  initial begin
    #2000000;
    errors++;
    summarize();
  end

  initial begin
    errors = 0;
    num_checks = 0;
    presetn = 1'b0;
    psel = 2'h0;
    penable = 2'h0;
    pwrite = 2'h0;
    paddr = '{8'h00, 8'h00};
    pwdata = '{32'h0, 32'h0};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    test_cross();
    test_lanes();
    test_burst();
    test_collide();
    summarize();
  end
endmodule
